/* File: inc/mcu_memory_map_params.svh */
// address map and register constants of the memory decoder
//
// Behaviour
// RL1: addresses 0x0020-0x00FF, 224 bytes, are shared user and stack RAM.
// RL2: an interrupt frame pushes five bytes of CPU registers into RAM.
// RL3: a subroutine call pushes a two-byte return address into RAM.
// RL4: stack pointer decrements per pushed byte, increments per pulled byte.
// RL5: addresses 0x0700-0x1EF7, 6136 bytes, are read-only user program memory.
// RL6: addresses 0x1EF8-0x1EFF are eight read-only security code bytes.
// RL7: addresses 0x1FF0-0x1FFF are 16 read-only vector and watchdog bytes.
// RL8: reset, software and external vectors at fixed addresses, high byte first.
// RL9: core timer, programmable timer, serial and analog vectors at fixed addresses.
// RL10: watchdog service at 0x1FF0 outside I/O; 0x1FF1 unused; vectors above.
// RL11: port A direction has six bits; bits 7-6 of direction and data read zero.
// RL12: port B direction at 0x0005 holds eight read/write bits.
// RL13: port C data, direction and pulldowns exist only in the larger build.
// RL14: pulldown inhibit at 0x0010 write-only: bits 5-0 port A, 7/6 port C halves.
// RL15: capture value read-only at 0x0014/0x0015; writes have no effect.
// RL16: compare value read/write at 0x0016 high and 0x0017 low.
// RL17: timer counter read at 0x0018/0x0019; writes ignored.
// RL18: alternate counter read at 0x001A/0x001B; writes ignored.
// RL19: I/O registers occupy 0x0000-0x001F, reached by ordinary memory accesses.
// RL20: unimplemented and reserved I/O locations read zero and ignore writes.
`ifndef MCU_MEMORY_MAP_PARAMS_SVH
`define MCU_MEMORY_MAP_PARAMS_SVH

`define ADDR_W 13
`define IO_LAST 13'h001f
`define RAM_FIRST 13'h0020
`define RAM_LAST 13'h00ff
`define RAM_DEPTH 224
`define ROM_FIRST 13'h0700
`define ROM_LAST 13'h1ef7
`define SEC_FIRST 13'h1ef8
`define SEC_LAST 13'h1eff
`define VEC_FIRST 13'h1ff0
`define VEC_LAST 13'h1fff
`define WATCHDOG_ADDR 13'h1ff0
`define UNUSED_ADDR 13'h1ff1

`define VEC_RESET 13'h1ffe
`define VEC_SOFTWARE 13'h1ffc
`define VEC_EXTERNAL 13'h1ffa
`define VEC_CORE_TIMER 13'h1ff8
`define VEC_PROG_TIMER 13'h1ff6
`define VEC_SERIAL 13'h1ff4
`define VEC_ANALOG 13'h1ff2

`define OFS_PORT_A 5'h00
`define OFS_PORT_B 5'h01
`define OFS_PORT_C 5'h02
`define OFS_ANALOG_SEL 5'h03
`define OFS_DIR_A 5'h04
`define OFS_DIR_B 5'h05
`define OFS_DIR_C 5'h06
`define OFS_CORE_TIMER_CTRL 5'h08
`define OFS_CORE_TIMER_COUNT 5'h09
`define OFS_SERIAL_CTRL 5'h0a
`define OFS_SERIAL_FLAGS 5'h0b
`define OFS_SERIAL_DATA 5'h0c
`define OFS_EXT_IRQ 5'h0d
`define OFS_PULLDOWN_AC 5'h10
`define OFS_PULLDOWN_B 5'h11
`define OFS_PTIMER_CTRL 5'h12
`define OFS_PTIMER_FLAGS 5'h13
`define OFS_CAPTURE_HI 5'h14
`define OFS_CAPTURE_LO 5'h15
`define OFS_COMPARE_HI 5'h16
`define OFS_COMPARE_LO 5'h17
`define OFS_COUNT_HI 5'h18
`define OFS_COUNT_LO 5'h19
`define OFS_ALT_HI 5'h1a
`define OFS_ALT_LO 5'h1b
`define OFS_ANALOG_CTRL 5'h1d
`define OFS_ANALOG_FLAGS 5'h1e

`define PORT_A_MASK 8'h3f
`define PULLDOWN_C_HI_BIT 7
`define PULLDOWN_C_LO_BIT 6
`define BYTE_RESET 8'h00
`define SP_LOW_RESET 6'h3f
`define SP_HIGH_BITS 2'b11
`define FRAME_INTERRUPT 3'h5
`define FRAME_CALL 3'h2

`endif

/* File: inc/mcu_memory_map_pkg.sv */
// types of the memory decoder
package mcu_memory_map_pkg;
`include "mcu_memory_map_params.svh"

    typedef struct packed {
        logic rd;
        logic wr;
        logic [`ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;

    // values owned by the peripherals, shown through the I/O window
    typedef struct packed {
        logic [7:0] core_timer_ctrl_flags;
        logic [7:0] core_timer_count;
        logic [7:0] serial_control;
        logic [7:0] serial_flags;
        logic [7:0] serial_shift_data;
        logic [7:0] ext_interrupt_ctrl_flags;
        logic [7:0] prog_timer_control;
        logic [7:0] prog_timer_flags;
        logic [15:0] capture_value;
        logic [15:0] free_count;
        logic [15:0] alt_count;
        logic [7:0] analog_flags;
    } periph_status_type;

    typedef struct packed {
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
        logic [7:0] port_a_latch;
        logic [7:0] port_b_latch;
        logic [7:0] port_c_latch;
        logic [7:0] port_a_c_pulldown_inhibit;
        logic [7:0] port_b_pulldown_inhibit;
        logic [7:0] analog_input_select;
        logic [7:0] analog_control;
        logic [15:0] compare_value;
    } io_regs_type;

    typedef enum logic [5:0] {
        REGION_IO = 6'b000001,
        REGION_RAM = 6'b000010,
        REGION_ROM = 6'b000100,
        REGION_SEC = 6'b001000,
        REGION_VEC = 6'b010000,
        REGION_NONE = 6'b100000
    } region_type;

    typedef enum logic [3:0] {
        SRC_RESET = 4'h0,
        SRC_SOFTWARE = 4'h1,
        SRC_EXTERNAL = 4'h2,
        SRC_CORE_TIMER = 4'h3,
        SRC_PROG_TIMER = 4'h4,
        SRC_SERIAL = 4'h5,
        SRC_ANALOG = 4'h6
    } vector_src_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_STACK = 4'b0010,
        ST_VEC_HI = 4'b0100,
        ST_VEC_LO = 4'b1000
    } state_type;

    // byte 0 is pushed first
    typedef struct packed {
        logic [2:0] length;
        logic [4:0][7:0] bytes;
    } stack_frame_type;

    typedef struct packed {
        logic wr;
        logic [4:0] offset;
        logic [7:0] data;
    } periph_write_type;

    typedef struct packed {
        state_type state;
        logic busy;
        logic [`RAM_DEPTH-1:0][7:0] ram;
        io_regs_type regs;
        logic [5:0] sp_low;
        stack_frame_type frame;
        logic [2:0] frame_index;
        logic [`ADDR_W-1:0] rom_addr;
        logic rd_pending;
        region_type rd_region;
        logic [`ADDR_W-1:0] rd_addr;
        logic [7:0] rdata;
        logic rdata_valid;
        logic pull_pending;
        logic [7:0] pull_data;
        logic pull_valid;
        logic [7:0] vec_hi;
        logic [15:0] vector;
        logic vector_valid;
        logic watchdog_service;
        periph_write_type periph_write;
        logic [7:0] pin_a_meta;
        logic [7:0] pin_a_sync;
        logic [7:0] pin_b_meta;
        logic [7:0] pin_b_sync;
        logic [7:0] pin_c_meta;
        logic [7:0] pin_c_sync;
    } decoder_state_type;

endpackage : mcu_memory_map_pkg

/* File: design/mcu_memory_map_decoder.sv */
// memory map decoder: I/O registers, stack RAM, ROM routing and vector fetch
module mcu_memory_map_decoder #(
    parameter bit HAS_PORT_C = 1'b1
) (
    input wire logic clock,
    input wire logic rst,
    input mcu_memory_map_pkg::cpu_req_type cpu_req,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic busy,
    input wire logic push_req,
    input mcu_memory_map_pkg::stack_frame_type push_frame,
    input wire logic pull_req,
    output logic [7:0] pull_data,
    output logic pull_valid,
    output logic [15:0] stack_pointer,
    input wire logic sp_reset,
    input wire logic vector_req,
    input mcu_memory_map_pkg::vector_src_type vector_src,
    output logic [15:0] vector,
    output logic vector_valid,
    output logic [`ADDR_W-1:0] rom_addr,
    input wire logic [7:0] rom_data,
    input mcu_memory_map_pkg::periph_status_type periph_status,
    output mcu_memory_map_pkg::periph_write_type periph_write,
    output mcu_memory_map_pkg::io_regs_type io_regs,
    output logic watchdog_service,
    input wire logic [7:0] port_a_pin,
    input wire logic [7:0] port_b_pin,
    input wire logic [7:0] port_c_pin
);
    import mcu_memory_map_pkg::*;

    decoder_state_type state_q;
    decoder_state_type state_d;

    function automatic region_type decode(input logic [`ADDR_W-1:0] a);
        region_type r;
        r = REGION_NONE;
        if (a <= `IO_LAST)
            r = REGION_IO; // RL19
        else if (a >= `RAM_FIRST && a <= `RAM_LAST)
            r = REGION_RAM; // RL1
        else if (a >= `ROM_FIRST && a <= `ROM_LAST)
            r = REGION_ROM; // RL5
        else if (a >= `SEC_FIRST && a <= `SEC_LAST)
            r = REGION_SEC; // RL6
        else if (a >= `VEC_FIRST && a <= `VEC_LAST)
            r = REGION_VEC; // RL7
        return r;
    endfunction : decode

    function automatic logic [`ADDR_W-1:0] vector_addr(input vector_src_type s);
        logic [`ADDR_W-1:0] a;
        a = `VEC_RESET;
        unique case (s)
            SRC_RESET: a = `VEC_RESET; // RL8
            SRC_SOFTWARE: a = `VEC_SOFTWARE; // RL8
            SRC_EXTERNAL: a = `VEC_EXTERNAL; // RL8
            SRC_CORE_TIMER: a = `VEC_CORE_TIMER; // RL9
            SRC_PROG_TIMER: a = `VEC_PROG_TIMER; // RL9
            SRC_SERIAL: a = `VEC_SERIAL; // RL9
            SRC_ANALOG: a = `VEC_ANALOG; // RL9
            default: a = `VEC_RESET;
        endcase
        return a;
    endfunction : vector_addr

    function automatic logic [7:0] ram_index(input logic [`ADDR_W-1:0] a);
        logic [`ADDR_W-1:0] d;
        d = a - `RAM_FIRST;
        return d[7:0];
    endfunction : ram_index

    // output bits show the latch, input bits show the synchronised pin
    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction : port_view

    function automatic logic [7:0] io_read(input logic [4:0] ofs, input decoder_state_type s,
                                           input periph_status_type p);
        logic [7:0] v;
        v = `BYTE_RESET; // RL20
        unique case (ofs)
            `OFS_PORT_A:
                v = port_view(s.regs.port_a_direction, s.regs.port_a_latch,
                              s.pin_a_sync) & `PORT_A_MASK; // RL11
            `OFS_PORT_B:
                v = port_view(s.regs.port_b_direction, s.regs.port_b_latch, s.pin_b_sync);
            `OFS_PORT_C:
                if (HAS_PORT_C)
                    v = port_view(s.regs.port_c_direction, s.regs.port_c_latch,
                                  s.pin_c_sync); // RL13
            `OFS_ANALOG_SEL: v = s.regs.analog_input_select;
            `OFS_DIR_A: v = s.regs.port_a_direction & `PORT_A_MASK; // RL11
            `OFS_DIR_B: v = s.regs.port_b_direction; // RL12
            `OFS_DIR_C:
                if (HAS_PORT_C)
                    v = s.regs.port_c_direction; // RL13
            `OFS_CORE_TIMER_CTRL: v = p.core_timer_ctrl_flags;
            `OFS_CORE_TIMER_COUNT: v = p.core_timer_count;
            `OFS_SERIAL_CTRL: v = p.serial_control;
            `OFS_SERIAL_FLAGS: v = p.serial_flags;
            `OFS_SERIAL_DATA: v = p.serial_shift_data;
            `OFS_EXT_IRQ: v = p.ext_interrupt_ctrl_flags;
            `OFS_PTIMER_CTRL: v = p.prog_timer_control;
            `OFS_PTIMER_FLAGS: v = p.prog_timer_flags;
            `OFS_CAPTURE_HI: v = p.capture_value[15:8]; // RL15
            `OFS_CAPTURE_LO: v = p.capture_value[7:0]; // RL15
            `OFS_COMPARE_HI: v = s.regs.compare_value[15:8]; // RL16
            `OFS_COMPARE_LO: v = s.regs.compare_value[7:0]; // RL16
            `OFS_COUNT_HI: v = p.free_count[15:8]; // RL17
            `OFS_COUNT_LO: v = p.free_count[7:0]; // RL17
            `OFS_ALT_HI: v = p.alt_count[15:8]; // RL18
            `OFS_ALT_LO: v = p.alt_count[7:0]; // RL18
            `OFS_ANALOG_CTRL: v = s.regs.analog_control;
            `OFS_ANALOG_FLAGS: v = p.analog_flags;
            // pulldown inhibits are write-only and read zero
            default: v = `BYTE_RESET; // RL14 RL20
        endcase
        return v;
    endfunction : io_read

    always_comb
    begin
        logic [7:0] idx;
        logic [7:0] sp_full;
        logic [`ADDR_W-1:0] a;
        logic [4:0] ofs;
        idx = 8'h00;
        sp_full = 8'h00;
        a = cpu_req.addr;
        ofs = a[4:0];
        state_d = state_q;
        state_d.rdata_valid = 1'b0;
        state_d.pull_valid = 1'b0;
        state_d.vector_valid = 1'b0;
        state_d.watchdog_service = 1'b0;
        state_d.periph_write = '0;

        state_d.pin_a_meta = port_a_pin;
        state_d.pin_a_sync = state_q.pin_a_meta;
        state_d.pin_b_meta = port_b_pin;
        state_d.pin_b_sync = state_q.pin_b_meta;
        state_d.pin_c_meta = port_c_pin;
        state_d.pin_c_sync = state_q.pin_c_meta;

        // second half of a read: rom data arrives one cycle after rom_addr
        state_d.rd_pending = 1'b0;
        if (state_q.rd_pending)
        begin
            state_d.rdata_valid = 1'b1;
            unique case (state_q.rd_region)
                REGION_IO: state_d.rdata = io_read(state_q.rd_addr[4:0], state_q, periph_status);
                REGION_RAM: state_d.rdata = state_q.ram[ram_index(state_q.rd_addr)]; // RL1
                REGION_ROM, REGION_SEC: state_d.rdata = rom_data; // RL5 RL6
                REGION_VEC:
                    if (state_q.rd_addr == `WATCHDOG_ADDR || state_q.rd_addr == `UNUSED_ADDR)
                        state_d.rdata = `BYTE_RESET; // RL10
                    else
                        state_d.rdata = rom_data; // RL7
                REGION_NONE: state_d.rdata = `BYTE_RESET;
            endcase
        end

        state_d.pull_pending = 1'b0;
        if (state_q.pull_pending)
        begin
            sp_full = {`SP_HIGH_BITS, state_q.sp_low};
            state_d.pull_data = state_q.ram[ram_index({5'h00, sp_full})];
            state_d.pull_valid = 1'b1;
        end

        unique case (state_q.state)
            ST_IDLE:
            begin
                if (sp_reset)
                    state_d.sp_low = `SP_LOW_RESET;
                else if (push_req && push_frame.length != 3'h0)
                begin
                    state_d.frame = push_frame; // RL2 RL3
                    state_d.frame_index = 3'h0;
                    state_d.state = ST_STACK;
                end
                else if (pull_req)
                begin
                    state_d.sp_low = state_q.sp_low + 6'h01; // RL4
                    state_d.pull_pending = 1'b1;
                end
                else if (vector_req)
                begin
                    state_d.rom_addr = vector_addr(vector_src); // RL8 RL9
                    state_d.state = ST_VEC_HI;
                end
                else if (cpu_req.rd)
                begin
                    state_d.rom_addr = a;
                    state_d.rd_addr = a;
                    state_d.rd_region = decode(a);
                    state_d.rd_pending = 1'b1;
                end
                else if (cpu_req.wr)
                begin
                    unique case (decode(a))
                        REGION_RAM: state_d.ram[ram_index(a)] = cpu_req.wdata; // RL1
                        REGION_IO:
                            unique case (ofs)
                                `OFS_PORT_A:
                                    state_d.regs.port_a_latch = cpu_req.wdata & `PORT_A_MASK;
                                `OFS_PORT_B: state_d.regs.port_b_latch = cpu_req.wdata;
                                `OFS_PORT_C:
                                    if (HAS_PORT_C)
                                        state_d.regs.port_c_latch = cpu_req.wdata; // RL13
                                `OFS_ANALOG_SEL: state_d.regs.analog_input_select = cpu_req.wdata;
                                `OFS_DIR_A:
                                    state_d.regs.port_a_direction =
                                        cpu_req.wdata & `PORT_A_MASK; // RL11
                                `OFS_DIR_B: state_d.regs.port_b_direction = cpu_req.wdata; // RL12
                                `OFS_DIR_C:
                                    if (HAS_PORT_C)
                                        state_d.regs.port_c_direction = cpu_req.wdata; // RL13
                                `OFS_PULLDOWN_AC:
                                begin
                                    // port C halves only stick in the larger build
                                    state_d.regs.port_a_c_pulldown_inhibit =
                                        cpu_req.wdata & `PORT_A_MASK; // RL14
                                    if (HAS_PORT_C)
                                    begin
                                        state_d.regs.port_a_c_pulldown_inhibit[`PULLDOWN_C_HI_BIT] =
                                            cpu_req.wdata[`PULLDOWN_C_HI_BIT]; // RL13 RL14
                                        state_d.regs.port_a_c_pulldown_inhibit[`PULLDOWN_C_LO_BIT] =
                                            cpu_req.wdata[`PULLDOWN_C_LO_BIT]; // RL13 RL14
                                    end
                                end
                                `OFS_PULLDOWN_B: state_d.regs.port_b_pulldown_inhibit = cpu_req.wdata;
                                `OFS_COMPARE_HI:
                                    state_d.regs.compare_value[15:8] = cpu_req.wdata; // RL16
                                `OFS_COMPARE_LO:
                                    state_d.regs.compare_value[7:0] = cpu_req.wdata; // RL16
                                `OFS_ANALOG_CTRL: state_d.regs.analog_control = cpu_req.wdata;
                                `OFS_CORE_TIMER_CTRL, `OFS_SERIAL_CTRL, `OFS_SERIAL_DATA,
                                `OFS_EXT_IRQ, `OFS_PTIMER_CTRL, `OFS_ANALOG_FLAGS:
                                begin
                                    // the owning peripheral applies its own write rules
                                    state_d.periph_write.wr = 1'b1;
                                    state_d.periph_write.offset = ofs;
                                    state_d.periph_write.data = cpu_req.wdata;
                                end
                                // capture, counters, serial flags, programmable timer flags and holes drop the write
                                default: state_d.periph_write.wr = 1'b0; // RL15 RL17 RL18 RL20
                            endcase
                        REGION_VEC:
                            if (a == `WATCHDOG_ADDR)
                                state_d.watchdog_service = 1'b1; // RL10
                        // program, security and unmapped space ignore writes
                        REGION_ROM, REGION_SEC, REGION_NONE: state_d.watchdog_service = 1'b0; // RL5 RL6
                    endcase
                end
            end
            ST_STACK:
            begin
                sp_full = {`SP_HIGH_BITS, state_q.sp_low};
                idx = ram_index({5'h00, sp_full});
                state_d.ram[idx] = state_q.frame.bytes[state_q.frame_index]; // RL2 RL3
                // the pointer wraps inside its 64-byte window, overwriting old frames
                state_d.sp_low = state_q.sp_low - 6'h01; // RL4
                state_d.frame_index = state_q.frame_index + 3'h1;
                if (state_q.frame_index + 3'h1 >= state_q.frame.length)
                    state_d.state = ST_IDLE;
            end
            ST_VEC_HI:
            begin
                state_d.vec_hi = rom_data; // RL8
                state_d.rom_addr = state_q.rom_addr + 13'h0001;
                state_d.state = ST_VEC_LO;
            end
            ST_VEC_LO:
            begin
                state_d.vector = {state_q.vec_hi, rom_data}; // RL8 RL9
                state_d.vector_valid = 1'b1;
                state_d.state = ST_IDLE;
            end
        endcase
        state_d.busy = (state_d.state != ST_IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '0;
            state_q.state <= ST_IDLE;
            state_q.rd_region <= REGION_NONE;
            state_q.sp_low <= `SP_LOW_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign rdata = state_q.rdata;
    assign rdata_valid = state_q.rdata_valid;
    assign busy = state_q.busy;
    assign pull_data = state_q.pull_data;
    assign pull_valid = state_q.pull_valid;
    assign stack_pointer = {8'h00, `SP_HIGH_BITS, state_q.sp_low};
    assign vector = state_q.vector;
    assign vector_valid = state_q.vector_valid;
    assign rom_addr = state_q.rom_addr;
    assign periph_write = state_q.periph_write;
    assign io_regs = state_q.regs;
    assign watchdog_service = state_q.watchdog_service;

endmodule : mcu_memory_map_decoder

/* File: test/mcu_memory_map_decoder_asserts.sv */
// port assertions for the memory map decoder
module mcu_memory_map_decoder_asserts
    import mcu_memory_map_pkg::*;
(
    input clock,
    input rst,
    input cpu_req_type cpu_req,
    input [7:0] rdata,
    input rdata_valid,
    input busy,
    input push_req,
    input stack_frame_type push_frame,
    input pull_req,
    input [15:0] stack_pointer,
    input sp_reset,
    input vector_req,
    input vector_valid,
    input periph_write_type periph_write,
    input io_regs_type io_regs,
    input watchdog_service
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic free;
    logic idle;
    // higher-priority requests outrank a cpu access
    assign free = !busy && !sp_reset;
    assign idle = free && !push_req && !pull_req && !vector_req;
    sequence wr_taken;
        idle && cpu_req.wr && !cpu_req.rd;
    endsequence
    a_read_answer: assert property (idle && cpu_req.rd |-> ##2 rdata_valid)
        else $error("read answer late");
    a_valid_cause: assert property (rdata_valid |-> $past(idle && cpu_req.rd, 2))
        else $error("read answer without request");
    a_port_a_top: assert property (idle && cpu_req.rd && cpu_req.addr inside {13'h0000, 13'h0004}
        |-> ##2 rdata[7:6] == 2'b00) else $error("port a top bits set");
    a_watchdog_pulse: assert property (wr_taken ##0 cpu_req.addr == 13'h1ff0 |=> watchdog_service)
        else $error("watchdog pulse missing");
    a_compare_write: assert property (wr_taken ##0 cpu_req.addr == 13'h0016
        |=> io_regs.compare_value[15:8] == $past(cpu_req.wdata)) else $error("compare");
    a_counts_ro: assert property (wr_taken ##0 cpu_req.addr inside {[13'h0014:13'h0015],
        [13'h0018:13'h001b]} |=> !periph_write.wr) else $error("read-only forwarded");
    a_sp_window: assert property (stack_pointer[15:6] == 10'h003)
        else $error("stack pointer out of window");
    a_push_call: assert property (free && push_req && push_frame.length == 3'h2
        |=> busy [*2] ##1 !busy) else $error("call push length");
    a_push_irq: assert property (free && push_req && push_frame.length == 3'h5 |=> busy [*5]
        ##1 stack_pointer[5:0] == $past(stack_pointer[5:0], 6) - 6'h5) else $error("irq");
    a_pull_step: assert property (free && !push_req && pull_req
        |=> stack_pointer[5:0] == $past(stack_pointer[5:0]) + 6'h1) else $error("pull");
    a_vector_done: assert property (free && !push_req && !pull_req && vector_req
        |-> ##3 vector_valid) else $error("vector late");
endmodule : mcu_memory_map_decoder_asserts

bind mcu_memory_map_decoder mcu_memory_map_decoder_asserts chk (.*);

/* File: test/rom_model.sv */
// external program memory model
module rom_model
(
    input wire logic [12:0] rom_addr,
    output logic [7:0] rom_data
);
    // every address bit changes the data, so a misrouted fetch shows
    assign rom_data = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]};
endmodule : rom_model

/* File: test/tb_top.sv */
// self-checking bench for the memory map decoder
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mcu_memory_map_pkg::*;
    logic clock, rst, push_req, pull_req, sp_reset, vector_req, rdata_valid, busy;
    logic pull_valid, vector_valid, watchdog_service;
    logic [7:0] rdata, pull_data, rom_data, got;
    logic [12:0] rom_addr;
    logic [15:0] stack_pointer, vector;
    cpu_req_type cpu_req;
    stack_frame_type push_frame;
    vector_src_type vector_src;
    periph_status_type periph_status;
    periph_write_type periph_write;
    io_regs_type io_regs;
    int n_mismatch, tests_run;
    mcu_memory_map_decoder DUT (.*, .port_a_pin(8'h00), .port_b_pin(8'h00), .port_c_pin(8'h00));
    rom_model ROM (.*);
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    function automatic logic [7:0] rom_of(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction : rom_of
    task check(input logic [15:0] g, e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 8 && s !== 1'b1; i++)
            @(negedge clock);
        if (s !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch at %0t: no answer", $time);
            end_of_test;
        end
    endtask : wait_hi
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask : pulse
    task rd(input logic [12:0] a);
        cpu_req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clock);
        cpu_req.rd = 1'b0;
        wait_hi(rdata_valid);
        got = rdata;
    endtask : rd
    task wr(input logic [12:0] a, input logic [7:0] d);
        cpu_req = '{1'b0, 1'b1, a, d};
        @(negedge clock);
        cpu_req.wr = 1'b0;
    endtask : wr
    task wr_rd(input logic [12:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        rd(a);
        check({8'h00, got}, {8'h00, e});
        @(negedge clock);
    endtask : wr_rd
    task t_registers;
        wr_rd(13'h0016, 8'h5a, 8'h5a);
        wr_rd(13'h0017, 8'hc3, 8'hc3);
        wr_rd(13'h0014, 8'hff, 8'h12);
        wr_rd(13'h0015, 8'h00, 8'h34);
        wr_rd(13'h0018, 8'hff, 8'h56);
        wr_rd(13'h0019, 8'hff, 8'h78);
        wr_rd(13'h001a, 8'hff, 8'h9a);
        wr_rd(13'h001b, 8'hff, 8'hbc);
        wr_rd(13'h001f, 8'hff, 8'h00);
        wr_rd(13'h0007, 8'hff, 8'h00);
        wr_rd(13'h0004, 8'hff, 8'h3f);
        wr_rd(13'h0000, 8'hff, 8'h3f);
        wr_rd(13'h0005, 8'hff, 8'hff);
        wr_rd(13'h0001, 8'ha5, 8'ha5);
        wr_rd(13'h0006, 8'hff, 8'hff);
        wr_rd(13'h0010, 8'hff, 8'h00);
        check({8'h00, io_regs.port_a_c_pulldown_inhibit}, 16'h00ff);
    endtask : t_registers
    task t_memory;
        wr_rd(13'h0020, 8'h11, 8'h11);
        wr_rd(13'h00ff, 8'h22, 8'h22);
        wr_rd(13'h0700, 8'hff, rom_of(13'h0700));
        wr_rd(13'h1ef7, 8'hff, rom_of(13'h1ef7));
        wr_rd(13'h1ef8, 8'hff, rom_of(13'h1ef8));
        wr_rd(13'h1fff, 8'hff, rom_of(13'h1fff));
        wr_rd(13'h1ff1, 8'hff, 8'h00);
        wr(13'h1ff0, 8'h00);
        check({15'h0, watchdog_service}, 16'h0001);
    endtask : t_memory
    task t_vectors;
        logic [12:0] hi;
        for (int k = 0; k < 7; k++)
        begin
            hi = 13'h1ffe - 13'(2 * k);
            vector_src = vector_src_type'(k);
            pulse(vector_req);
            wait_hi(vector_valid);
            check(vector, {rom_of(hi), rom_of(hi + 13'h1)});
            @(negedge clock);
        end
    endtask : t_vectors
    task t_stack;
        pulse(sp_reset);
        push_frame = '{3'h5, {8'h55, 8'h44, 8'h33, 8'h22, 8'h11}};
        pulse(push_req);
        repeat (6) @(negedge clock);
        check(stack_pointer, 16'h00fa);
        rd(13'h00ff);
        check({8'h00, got}, 16'h0011);
        pulse(pull_req);
        wait_hi(pull_valid);
        check({8'h00, pull_data}, 16'h0055);
        push_frame = '{3'h2, {24'h0, 8'hcc, 8'hdd}};
        pulse(push_req);
        repeat (3) @(negedge clock);
        check(stack_pointer, 16'h00f9);
        rd(13'h00fa);
        check({8'h00, got}, 16'h00cc);
    endtask : t_stack
    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        rst = 1'b1;
        cpu_req = '0;
        {push_req, pull_req, sp_reset, vector_req} = 4'h0;
        vector_src = SRC_RESET;
        push_frame = '0;
        periph_status = '0;
        periph_status.capture_value = 16'h1234;
        periph_status.free_count = 16'h5678;
        periph_status.alt_count = 16'h9abc;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        check(stack_pointer, 16'h00ff);
        t_registers;
        t_memory;
        t_vectors;
        t_stack;
        end_of_test;
    end
endmodule : tb_top
